// ===== ptab_map.svh
// Offsets, field positions, reset values and timing counts of the table access block
`ifndef PTAB_MAP_SVH
`define PTAB_MAP_SVH

// Register select codes on the core's special-function port
`define PTAB_SEL_CONTROL   3'h0
`define PTAB_SEL_KEY       3'h1
`define PTAB_SEL_EEADDR    3'h2
`define PTAB_SEL_EEVALUE   3'h3
`define PTAB_SEL_LATCH     3'h4
`define PTAB_SEL_PTR_UP    3'h5
`define PTAB_SEL_PTR_HI    3'h6
`define PTAB_SEL_PTR_LO    3'h7

// Control register field positions
`define PTAB_BIT_RD        0
`define PTAB_BIT_WR        1
`define PTAB_BIT_WRITE_ENABLE_BIT      2
`define PTAB_BIT_ERR       3
`define PTAB_BIT_ERASE     4
`define PTAB_BIT_CFG       6
`define PTAB_BIT_MEM       7

// Unlock key bytes
`define PTAB_KEY_FIRST     8'h55
`define PTAB_KEY_SECOND    8'hAA

// Holding register erased value
`define PTAB_HOLD_RESET    8'hFF

// Self-timed cycle: about 2 ms at 200 MHz
`define PTAB_PROG_TIME_US  2000
`define PTAB_CLK_MHZ       200
`define PTAB_PROG_CYCLES   (`PTAB_PROG_TIME_US * `PTAB_CLK_MHZ)

`endif

// ===== ptab_pkg.sv
// Types shared by the table access block
package ptab_pkg;

    // Pointer update behaviour of a table instruction
    typedef enum logic [1:0] {
        PTAB_PTR_KEEP,
        PTAB_PTR_POST_INC,
        PTAB_PTR_POST_DEC,
        PTAB_PTR_PRE_INC
    } ptab_ptr_mode_e;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        PTAB_KEY_IDLE,
        PTAB_KEY_GOT_FIRST,
        PTAB_KEY_ARMED
    } ptab_key_e;

    // Self-timed operation progress
    typedef enum logic [1:0] {
        PTAB_OP_IDLE,
        PTAB_OP_BUSY,
        PTAB_OP_DONE
    } ptab_op_e;

endpackage

// ===== ptab_timer.sv
// Self-timed programming timer for the table access block
`timescale 1ns/1ps
`default_nettype none

module ptab_timer #(
    parameter int unsigned CYCLES = 400000      // Length of a long write
) (
    input  wire logic clk_sys_in,               // System clock
    input  wire logic rst_in,                   // Synchronous reset
    input  wire logic start_in,                 // Begin a timed cycle
    output logic      busy_out,                 // Timer running
    output logic      done_out                  // One-cycle expiry pulse
);

    // All timer state in one struct
    typedef struct packed {
        logic [31:0] count;                     // Cycles left
        logic        busy;                      // Running
        logic        done;                      // Expiry pulse
    } ptab_tmr_s;

    ptab_tmr_s tmr_q;                            // Registered state
    ptab_tmr_s tmr_d;                            // Next state

    ////////////////////////////////////////////////////////////////////////
    // Countdown; nobody outside times the cycle
    always_comb begin
        tmr_d      = tmr_q;
        tmr_d.done = 1'b0;
        if (!tmr_q.busy && start_in) begin
            tmr_d.busy  = 1'b1;
            tmr_d.count = 32'(CYCLES - 1);
        end else if (tmr_q.busy) begin
            if (tmr_q.count == 32'h0) begin
                tmr_d.busy = 1'b0;              // [R4]
                tmr_d.done = 1'b1;              // [R4]
            end else begin
                tmr_d.count = tmr_q.count - 32'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    assign busy_out = tmr_q.busy;
    assign done_out = tmr_q.done;

endmodule

`default_nettype wire

// ===== ptab_ctrl.sv
// Table read/write, unlock and self-timed program control for the core
// Behaviour
// [R1] Read bytes, program 8, erase 64
// [R2] No bulk erase from the core
// [R3] Stall fetch during flash or config write or erase
// [R4] Internal timer ends every long cycle
// [R5] Table read uses all 22 pointer bits
// [R6] Table write fills holding register only
// [R7] Core keeps code writes word aligned
// [R8] Key port stores nothing, reads zero
// [R9] Memory select: 0 EEPROM, 1 flash
// [R10] Configuration select overrides memory select
// [R11] Erase bit erases row, cleared after
// [R12] Writes need enable bit, reset zero
// [R13] Error flag on aborted write, selects kept
// [R14] Write bit set-only, hardware clears
// [R15] Completion sets done flag, software clears
// [R16] Read bit one-cycle EEPROM read, guarded
// [R17] Table latch is 8-bit register
// [R18] Three bytes form 22-bit pointer
// [R19] Four pointer modes, low 21 bits
// [R20] Low three bits pick holding register
// [R21] Bits 21:3 pick programmed block
// [R22] Bits 21:6 pick erased row
// [R23] Key 55h then AAh before start
// [R24] Enable must precede write bit
// [R25] Holding bytes reset FFh, FFh keeps
// [R26] Registers frozen while cycle runs
`timescale 1ns/1ps
`default_nettype none
`include "ptab_map.svh"

module ptab_ctrl (
    input  wire logic        clk_sys_in,        // System clock
    input  wire logic        rst_in,            // Synchronous reset
    input  wire logic        por_in,            // Reset came from power-up
    // Special-function register port
    input  wire logic [2:0]  sfr_sel_in,        // Register select
    input  wire logic        sfr_wr_in,         // Write strobe
    input  wire logic [7:0]  sfr_wdata_in,      // Write data
    output logic      [7:0]  sfr_rdata_out,     // Read data
    // Table instruction port
    input  wire logic        tbl_rd_in,         // Table read strobe
    input  wire logic        tbl_wr_in,         // Table write strobe
    input  wire logic [1:0]  tbl_mode_in,       // Pointer behaviour
    // Program / configuration / EEPROM arrays
    output logic      [21:0] mem_addr_out,      // Array byte address
    input  wire logic [7:0]  mem_rdata_in,      // Array read byte
    input  wire logic [7:0]  ee_rdata_in,       // EEPROM read byte
    output logic             ee_rd_out,         // EEPROM read pulse
    output logic      [7:0]  ee_addr_out,       // EEPROM byte address
    output logic      [7:0]  ee_wdata_out,      // EEPROM write byte
    output logic             prog_out,          // Long write in flight
    output logic             prog_erase_out,    // Long cycle is row erase
    output logic      [1:0]  prog_target_out,   // 0 EEPROM,1 flash,2 cfg
    output logic      [63:0] prog_data_out,     // Holding bytes, FFh keep
    // Core and flag
    output logic             fetch_stall_out,   // Halt instruction fetch
    output logic             done_flag_set_out  // Set write done flag
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]  ctrl;                      // Control register
        logic [7:0]  eeaddr;                    // EEPROM address
        logic [7:0]  eevalue;                   // EEPROM value
        logic [7:0]  latch;                     // Table latch
        logic [21:0] ptr;                       // Table pointer
        logic [63:0] hold;                      // Eight holding bytes
        logic        write_enable_bit_old;                  // Enable held before write
        logic        erase_op;                  // Running cycle erases
        logic [1:0]  target;                    // Running cycle target
        logic [21:0] op_addr;                   // Running cycle address
        logic        ee_rd;                     // EEPROM read pulse
        logic        done_set;                  // Done flag pulse
        ptab_pkg::ptab_key_e key;               // Unlock progress
        ptab_pkg::ptab_op_e  op;                // Cycle progress
    } ptab_ctrl_s;

    ptab_ctrl_s st_q;                            // Registered state
    ptab_ctrl_s st_d;                            // Next state
    logic       tmr_busy;                        // Timer running
    logic       tmr_done;                        // Timer expired
    logic       start;                           // Launch a long cycle

    // Target decode: configuration wins over memory select
    function automatic logic [1:0] target_of(input logic [7:0] c);
        if (c[`PTAB_BIT_CFG]) begin
            target_of = 2'h2;                   // [R10]
        end else if (c[`PTAB_BIT_MEM]) begin
            target_of = 2'h1;                   // [R9]
        end else begin
            target_of = 2'h0;                   // [R9]
        end
    endfunction

    // Pointer step on the low 21 bits only; top bit stays put
    function automatic logic [21:0] step(input logic [21:0] p,
                                         input logic        up);
        step = {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1}; // [R19]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Programming timer
    ptab_timer #(
        .CYCLES (`PTAB_PROG_CYCLES)
    ) u_timer (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .start_in   (start),
        .busy_out   (tmr_busy),
        .done_out   (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [21:0] rptr;
        logic [7:0]  w;
        logic        busy;
        rptr     = st_q.ptr;
        w        = sfr_wdata_in;
        busy     = (st_q.op != ptab_pkg::PTAB_OP_IDLE);
        st_d     = st_q;
        start    = 1'b0;
        st_d.ee_rd    = 1'b0;
        st_d.done_set = 1'b0;
        st_d.write_enable_bit_old = st_q.ctrl[`PTAB_BIT_WRITE_ENABLE_BIT];

        // Control-space writes are frozen while a cycle runs
        if (sfr_wr_in && !busy) begin           // [R26]
            // Any write other than the key breaks the unlock sequence
            if (sfr_sel_in != `PTAB_SEL_KEY) begin
                st_d.key = ptab_pkg::PTAB_KEY_IDLE;
            end
            unique case (sfr_sel_in)
                `PTAB_SEL_CONTROL: begin
                    // Plain bits; error flag is hardware only
                    st_d.ctrl[`PTAB_BIT_MEM]   = w[`PTAB_BIT_MEM];
                    st_d.ctrl[`PTAB_BIT_CFG]   = w[`PTAB_BIT_CFG];
                    st_d.ctrl[`PTAB_BIT_ERASE] = w[`PTAB_BIT_ERASE];
                    st_d.ctrl[`PTAB_BIT_WRITE_ENABLE_BIT]  = w[`PTAB_BIT_WRITE_ENABLE_BIT];
                    // Read bit: set only, blocked for flash/config
                    if (w[`PTAB_BIT_RD] && !w[`PTAB_BIT_MEM] &&
                        !w[`PTAB_BIT_CFG]) begin
                        st_d.ee_rd = 1'b1;      // [R16]
                    end
                    // Write bit: set only, never cleared here
                    if (w[`PTAB_BIT_WR]) begin  // [R14]
                        if (st_q.key == ptab_pkg::PTAB_KEY_ARMED && // [R23]
                            st_q.write_enable_bit_old &&    // [R24]
                            st_q.ctrl[`PTAB_BIT_WRITE_ENABLE_BIT]) begin // [R12]
                            st_d.ctrl[`PTAB_BIT_WR]  = 1'b1;
                            st_d.ctrl[`PTAB_BIT_ERR] = 1'b1;
                            st_d.op       = ptab_pkg::PTAB_OP_BUSY;
                            st_d.target   = target_of(w);
                            st_d.erase_op = w[`PTAB_BIT_ERASE];
                            // Row or block address; low bits ignored
                            st_d.op_addr  = w[`PTAB_BIT_ERASE] ?
                                {st_q.ptr[21:6], 6'h00} : // [R22]
                                {st_q.ptr[21:3], 3'h0};   // [R21]
                            start = 1'b1;
                        end else begin
                            st_d.ctrl[`PTAB_BIT_ERR] = 1'b1; // [R13]
                        end
                    end
                end
                `PTAB_SEL_KEY: begin
                    // Nothing stored, only sequence progress
                    if (w == `PTAB_KEY_FIRST) begin // [R23]
                        st_d.key = ptab_pkg::PTAB_KEY_GOT_FIRST;
                    end else if (w == `PTAB_KEY_SECOND &&
                        st_q.key == ptab_pkg::PTAB_KEY_GOT_FIRST) begin
                        st_d.key = ptab_pkg::PTAB_KEY_ARMED;
                    end else begin
                        st_d.key = ptab_pkg::PTAB_KEY_IDLE;
                    end
                end
                `PTAB_SEL_EEADDR: st_d.eeaddr  = w;
                `PTAB_SEL_EEVALUE: st_d.eevalue = w;
                `PTAB_SEL_LATCH:  st_d.latch   = w; // [R17]
                `PTAB_SEL_PTR_UP: st_d.ptr[21:16] = w[5:0]; // [R18]
                `PTAB_SEL_PTR_HI: st_d.ptr[15:8]  = w;      // [R18]
                `PTAB_SEL_PTR_LO: st_d.ptr[7:0]   = w;      // [R18]
            endcase
        end

        // One-cycle EEPROM read lands in the value register
        if (st_q.ee_rd) begin
            st_d.eevalue = ee_rdata_in;         // [R16]
        end

        // Table instructions; ignored while the array is busy
        if ((tbl_rd_in || tbl_wr_in) && !busy) begin
            if (tbl_mode_in == 2'(ptab_pkg::PTAB_PTR_PRE_INC)) begin
                rptr = step(st_q.ptr, 1'b1);    // [R19]
            end
            if (tbl_rd_in) begin
                st_d.latch = mem_rdata_in;      // [R5]
            end else begin
                // Latch goes to the holding slot, not the array
                st_d.hold[rptr[2:0]*8 +: 8] = st_q.latch; // [R6] [R20]
            end
            unique case (ptab_pkg::ptab_ptr_mode_e'(tbl_mode_in))
                ptab_pkg::PTAB_PTR_KEEP:     st_d.ptr = st_q.ptr;
                ptab_pkg::PTAB_PTR_POST_INC: st_d.ptr = step(st_q.ptr, 1'b1);
                ptab_pkg::PTAB_PTR_POST_DEC: st_d.ptr = step(st_q.ptr, 1'b0);
                ptab_pkg::PTAB_PTR_PRE_INC:  st_d.ptr = rptr;
            endcase
        end

        // Completion of the timed cycle
        if (st_q.op == ptab_pkg::PTAB_OP_BUSY && tmr_done) begin // [R4]
            st_d.op = ptab_pkg::PTAB_OP_DONE;
        end
        if (st_q.op == ptab_pkg::PTAB_OP_DONE) begin
            st_d.op = ptab_pkg::PTAB_OP_IDLE;
            st_d.ctrl[`PTAB_BIT_WR]    = 1'b0;  // [R14]
            st_d.ctrl[`PTAB_BIT_ERR]   = 1'b0;  // [R13]
            st_d.ctrl[`PTAB_BIT_ERASE] = 1'b0;  // [R11]
            st_d.done_set = 1'b1;               // [R15]
            // Holding bytes return to the keep value
            st_d.hold = {8{`PTAB_HOLD_RESET}}; // [R25]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; a non-power-up reset mid-cycle leaves the error flag up
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_q      <= '0;                    // [R12]
            st_q.hold <= {8{`PTAB_HOLD_RESET}}; // [R25]
            // Other resets keep selects for tracing, flag aborted cycle
            if (!por_in) begin
                st_q.ctrl[`PTAB_BIT_MEM] <= st_q.ctrl[`PTAB_BIT_MEM];
                st_q.ctrl[`PTAB_BIT_CFG] <= st_q.ctrl[`PTAB_BIT_CFG];
                st_q.ctrl[`PTAB_BIT_ERR] <= st_q.ctrl[`PTAB_BIT_ERR] ||
                    (st_q.op != ptab_pkg::PTAB_OP_IDLE); // [R13]
            end
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux
    always_comb begin
        unique case (sfr_sel_in)
            `PTAB_SEL_CONTROL: sfr_rdata_out = {st_q.ctrl[7:6], 1'b0,
                                                st_q.ctrl[4:1], 1'b0};
            `PTAB_SEL_KEY:     sfr_rdata_out = 8'h00; // [R8]
            `PTAB_SEL_EEADDR:  sfr_rdata_out = st_q.eeaddr;
            `PTAB_SEL_EEVALUE: sfr_rdata_out = st_q.eevalue;
            `PTAB_SEL_LATCH:   sfr_rdata_out = st_q.latch;
            `PTAB_SEL_PTR_UP:  sfr_rdata_out = {2'h0, st_q.ptr[21:16]};
            `PTAB_SEL_PTR_HI:  sfr_rdata_out = st_q.ptr[15:8];
            `PTAB_SEL_PTR_LO:  sfr_rdata_out = st_q.ptr[7:0];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Array side; only row-sized erases exist here, never bulk
    // Pre-increment read must see the stepped pointer this cycle
    assign mem_addr_out = (st_q.op != ptab_pkg::PTAB_OP_IDLE) ?
                          st_q.op_addr :
                          (tbl_rd_in && tbl_mode_in == 2'h3) ?
                          step(st_q.ptr, 1'b1) : st_q.ptr; // [R5] [R19]
    assign prog_out          = tmr_busy;                 // [R1]
    assign prog_erase_out    = st_q.erase_op;            // [R2] [R22]
    assign prog_target_out   = st_q.target;
    assign prog_data_out     = st_q.hold;                // [R25]
    assign ee_rd_out         = st_q.ee_rd;
    assign ee_addr_out       = st_q.eeaddr;
    assign ee_wdata_out      = st_q.eevalue;
    // Flash busy means no fetch; EEPROM writes let code run
    assign fetch_stall_out   = (st_q.op != ptab_pkg::PTAB_OP_IDLE) &&
                               (st_q.target != 2'h0);    // [R3]
    assign done_flag_set_out = st_q.done_set;            // [R15]

endmodule

`default_nettype wire

// ===== ptab_mem_model.sv
// Array model standing behind the table access block
`timescale 1ns/1ps
`default_nettype none

module ptab_mem_model (
    input  wire logic [21:0] addr_in,      // Program/config byte address
    input  wire logic [7:0]  ee_addr_in,   // EEPROM byte address
    output logic      [7:0]  rdata_out,    // Program/config byte
    output logic      [7:0]  ee_rdata_out  // EEPROM byte
);
    // Address-derived contents: XOR of low byte, high byte and upper byte shifted left two
    assign rdata_out    = addr_in[7:0] ^ addr_in[15:8] ^ {addr_in[21:16], 2'h0};
    // EEPROM holds the inverse of its address
    assign ee_rdata_out = ~ee_addr_in;
endmodule
`default_nettype wire

// ===== ptab_ctrl_chk.sv
// Port-level assertions for the table access block
`timescale 1ns/1ps
`default_nettype none
`include "ptab_map.svh"

module ptab_ctrl_chk (
    input  wire logic        clk_sys_in,        // System clock
    input  wire logic        rst_in,            // Synchronous reset
    input  wire logic [2:0]  sfr_sel_in,        // Register select
    input  wire logic        sfr_wr_in,         // Write strobe
    input  wire logic [7:0]  sfr_wdata_in,      // Write data
    input  wire logic [7:0]  sfr_rdata_out,     // Read data
    input  wire logic        tbl_rd_in,         // Table read strobe
    input  wire logic [1:0]  tbl_mode_in,       // Pointer behaviour
    input  wire logic [21:0] mem_addr_out,      // Array address
    input  wire logic [7:0]  mem_rdata_in,      // Array byte
    input  wire logic        ee_rd_out,         // EEPROM read pulse
    input  wire logic        prog_out,          // Long write busy
    input  wire logic [1:0]  prog_target_out,   // Cycle target
    input  wire logic [63:0] prog_data_out,     // Holding bytes
    input  wire logic        fetch_stall_out,   // Fetch halt
    input  wire logic        done_flag_set_out  // Done pulse
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////
    // Named steps of the control sequences
    sequence s_ctrl_wr;
        sfr_wr_in && sfr_sel_in == `PTAB_SEL_CONTROL;
    endsequence
    sequence s_rd_keep;
        tbl_rd_in && tbl_mode_in == 2'h0 && !prog_out &&
            sfr_sel_in == `PTAB_SEL_LATCH;
    endsequence

    ////////////////////////////////////////////////////////////////////
    // Flash or config cycles must halt fetch
    property p_stall;
        prog_out && prog_target_out != 2'h0 |-> fetch_stall_out;
    endproperty
    a_stall: assert property (p_stall) else $error("fetch not stalled");
    // Read pulse lasts a single cycle
    property p_rd_pulse;
        ee_rd_out |=> !ee_rd_out;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("long rd");
    // Read with a select bit set is blocked
    property p_rd_block;
        s_ctrl_wr ##0 (sfr_wdata_in[0] && sfr_wdata_in[7:6] != 2'h0)
            |=> !ee_rd_out;
    endproperty
    a_rd_block: assert property (p_rd_block) else $error("rd ran");
    // A read pulse always follows a register write with bit 0 set
    property p_rd_cause;
        ee_rd_out |-> $past(sfr_wr_in && sfr_wdata_in[0]);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("stray rd");
    // Key port reads zero
    property p_key;
        sfr_sel_in == `PTAB_SEL_KEY |-> sfr_rdata_out == 8'h00;
    endproperty
    a_key: assert property (p_key) else $error("key port nonzero");
    // Cycle only starts from a write-control write
    property p_start;
        $rose(prog_out) |-> $past(sfr_wr_in &&
            sfr_sel_in == `PTAB_SEL_CONTROL && sfr_wdata_in[1]);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    // Address and holding bytes frozen while busy
    property p_frozen;
        prog_out && $past(prog_out) |->
            $stable(mem_addr_out) && $stable(prog_data_out);
    endproperty
    a_frozen: assert property (p_frozen) else $error("moved");
    // Internal timer keeps the cycle up, not a bus event
    property p_len;
        $rose(prog_out) |-> prog_out [*8];
    endproperty
    a_len: assert property (p_len) else $error("cycle too short");
    // Table read lands the addressed byte in the latch
    property p_latch;
        s_rd_keep ##1 sfr_sel_in == `PTAB_SEL_LATCH
            |-> sfr_rdata_out == $past(mem_rdata_in);
    endproperty
    a_latch: assert property (p_latch) else $error("latch wrong");
    // Done request is a one-cycle pulse
    property p_done;
        done_flag_set_out |=> !done_flag_set_out;
    endproperty
    a_done: assert property (p_done) else $error("long done");
endmodule

bind ptab_ctrl ptab_ctrl_chk i_ptab_ctrl_chk (.*);
`default_nettype wire

// ===== ptab_ctrl_tb_top.sv
// Self-checking bench for the table access block
`timescale 1ns/1ps
`default_nettype none
`include "ptab_map.svh"

module ptab_ctrl_tb_top;
    logic        clk_sys_in = 1'b0;  // 200 MHz clock
    logic        rst_in     = 1'b1;  // Synchronous reset
    logic        por_in     = 1'b1;  // Power-up reset marker
    logic [2:0]  sel        = 3'h0;  // Register select
    logic        wstb       = 1'b0;  // Register write strobe
    logic [7:0]  wdat       = 8'h00; // Register write data
    logic        trd        = 1'b0;  // Table read strobe
    logic        twr        = 1'b0;  // Table write strobe
    logic [1:0]  tmode      = 2'h0;  // Pointer behaviour
    logic [7:0]  rdata, mrd, erd, eea, eew;
    logic [21:0] maddr;
    logic        ee_rd, prog, perase, stall, dset;
    logic [1:0]  ptgt;
    logic [63:0] pdata;
    int          miscompares = 0;
    int          checked     = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    ptab_ctrl i_ptab_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .por_in(por_in), .sfr_sel_in(sel), .sfr_wr_in(wstb),
        .sfr_wdata_in(wdat), .sfr_rdata_out(rdata), .tbl_rd_in(trd),
        .tbl_wr_in(twr), .tbl_mode_in(tmode), .mem_addr_out(maddr),
        .mem_rdata_in(mrd), .ee_rdata_in(erd), .ee_rd_out(ee_rd),
        .ee_addr_out(eea), .ee_wdata_out(eew), .prog_out(prog),
        .prog_erase_out(perase), .prog_target_out(ptgt),
        .prog_data_out(pdata), .fetch_stall_out(stall),
        .done_flag_set_out(dset));
    ptab_mem_model i_ptab_mem_model (.addr_in(maddr), .ee_addr_in(eea),
        .rdata_out(mrd), .ee_rdata_out(erd));

    ////////////////////////////////////////////////////////////////////
    // Expected array byte
    function automatic logic [7:0] fm(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {a[21:16], 2'h0};
    endfunction
    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register write, one edge
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk_sys_in);
        sel = s; wdat = d; wstb = 1'b1;
        @(negedge clk_sys_in);
        wstb = 1'b0;
    endtask
    // Combinational register read
    task automatic rd(input logic [2:0] s, input logic [7:0] e,
                      input string n);
        sel = s;
        #1 chk(n, e, rdata);
    endtask
    task automatic top(input logic w, input logic [1:0] m);
        @(negedge clk_sys_in);
        trd = !w; twr = w; tmode = m;
        @(negedge clk_sys_in);
        trd = 1'b0; twr = 1'b0;
    endtask
    // Upper bits 7:6 set, must drop
    task automatic setp(input logic [21:0] p);
        wr(`PTAB_SEL_PTR_UP, {2'h3, p[21:16]});
        wr(`PTAB_SEL_PTR_HI, p[15:8]);
        wr(`PTAB_SEL_PTR_LO, p[7:0]);
    endtask
    task automatic tstep(input logic [1:0] m, input logic [21:0] ea,
                         input logic [21:0] ep);
        sel = `PTAB_SEL_LATCH;
        top(1'b0, m);
        rd(`PTAB_SEL_LATCH, fm(ea), "latch");
        chk("pointer", ep, maddr);
    endtask
    task automatic unlock;
        wr(`PTAB_SEL_KEY, `PTAB_KEY_FIRST);
        wr(`PTAB_SEL_KEY, `PTAB_KEY_SECOND);
    endtask
    task automatic rst(input logic p);
        @(negedge clk_sys_in);
        rst_in = 1'b1; por_in = p;
        repeat (6) @(negedge clk_sys_in);
        rst_in = 1'b0; por_in = 1'b0;
    endtask
    task automatic tend(input string n);
        $display("test %s done", n);
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        rst(1'b1);
        rd(`PTAB_SEL_CONTROL, 8'h00, "ctrl");
        rd(`PTAB_SEL_KEY, 8'h00, "key");
        chk("hold", {8{8'hFF}}, pdata);
        tend("reset");
        setp(22'h3FFFFF);
        rd(`PTAB_SEL_PTR_UP, 8'h3F, "ptr_up");
        tstep(2'h0, 22'h3FFFFF, 22'h3FFFFF);
        tstep(2'h1, 22'h3FFFFF, 22'h200000);
        tstep(2'h2, 22'h200000, 22'h3FFFFF);
        tstep(2'h3, 22'h200000, 22'h200000);
        tend("pointer");
        wr(`PTAB_SEL_EEADDR, 8'h5A);
        wr(`PTAB_SEL_CONTROL, 8'h01);
        repeat (3) @(negedge clk_sys_in);
        rd(`PTAB_SEL_EEVALUE, 8'hA5, "ee_value");
        wr(`PTAB_SEL_EEADDR, 8'h3C);
        wr(`PTAB_SEL_CONTROL, 8'h81);
        wr(`PTAB_SEL_CONTROL, 8'h41);
        repeat (3) @(negedge clk_sys_in);
        rd(`PTAB_SEL_EEVALUE, 8'hA5, "ee_blocked");
        tend("eeprom");
        // Code store starts word aligned
        setp(22'h000100);
        for (int i = 0; i < 8; i++) begin
            wr(`PTAB_SEL_LATCH, 8'h10 + 8'(i));
            top(1'b1, 2'h1);
        end
        chk("hold", 64'h1716151413121110, pdata);
        chk("pointer", 22'h000108, maddr);
        tend("holding");
        wr(`PTAB_SEL_CONTROL, 8'h86);
        chk("prog", 1'b0, prog);
        rd(`PTAB_SEL_CONTROL, 8'h8C, "ctrl");
        wr(`PTAB_SEL_KEY, `PTAB_KEY_SECOND);
        wr(`PTAB_SEL_CONTROL, 8'h86);
        chk("prog", 1'b0, prog);
        tend("refuse");
        setp(22'h00010D);
        wr(`PTAB_SEL_CONTROL, 8'h84);
        unlock();
        wr(`PTAB_SEL_CONTROL, 8'h86);
        @(negedge clk_sys_in);
        chk("prog", 1'b1, prog);
        chk("stall", 1'b1, stall);
        chk("target", 2'h1, ptgt);
        chk("block", 19'h00021, maddr[21:3]);
        wr(`PTAB_SEL_PTR_LO, 8'h00);
        wr(`PTAB_SEL_CONTROL, 8'h04);
        rd(`PTAB_SEL_PTR_LO, 8'h0D, "ptr_lo");
        rd(`PTAB_SEL_CONTROL, 8'h8E, "ctrl");
        rst(1'b0);
        rd(`PTAB_SEL_CONTROL, 8'h88, "ctrl");
        chk("hold", {8{8'hFF}}, pdata);
        tend("flash");
        setp(22'h200345);
        wr(`PTAB_SEL_CONTROL, 8'hD4);
        unlock();
        wr(`PTAB_SEL_CONTROL, 8'hD6);
        @(negedge clk_sys_in);
        chk("erase", 1'b1, perase);
        chk("target", 2'h2, ptgt);
        chk("row", 16'h800D, maddr[21:6]);
        rst(1'b1);
        rd(`PTAB_SEL_CONTROL, 8'h00, "ctrl");
        tend("erase");
        wr(`PTAB_SEL_CONTROL, 8'h04);
        unlock();
        wr(`PTAB_SEL_CONTROL, 8'h06);
        @(negedge clk_sys_in);
        chk("target", 2'h0, ptgt);
        chk("stall", 1'b0, stall);
        rst(1'b1);
        tend("ee_write");
        finish_test();
    end
endmodule
`default_nettype wire
